// ==== logic/sdah_top.sv ====
// Alarm handler of a servo drive: alarm latch, code routing, lamp, history.
// Assumes protective events, warnings and plain outputs come from logic on clk;
// shared_clear_input and position_req_input are pins and are synchronised here.
//
// Notes on behaviour
// - Any alarm drops the alarm output and stops the motor.
// - Code output enabled: ready, limit, zero outputs carry code bits 0, 1, 2.
// - Position mode with position request on: no alarm code on shared outputs.
// - In that priority, shared clear input is only the position clock.
// - Alarm lamp blinks in groups; blinks per group name the cause.
// - Overvoltage blinks exactly three times per group.
// - Ten newest alarms kept, read newest first; a command clears them.
// - Fault clear input on then off; alarm clears at the off edge.
// - Active alarm readable by the tool interface.
// - Some alarms ignore input and tool reset; only power-up clears them.
// - Absolute position loss needs an extra arming step before reset.
// - Alarms that cut current engage the brake when one is fitted.
// - Warning shown for a condition before its alarm is raised.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module sdah_top
   import sdah_pkg::*;
#(
   parameter int unsigned BLINK_ON_CYC = SDAH_BLINK_ON_CYC,
   parameter int unsigned BLINK_GAP_CYC = SDAH_BLINK_GAP_CYC,
   parameter logic [SDAH_NCAUSE-1:0] CUT_CURRENT_MASK = 12'hfff
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [SDAH_NCAUSE-1:0] fault_event,
   input wire logic [SDAH_NCAUSE-1:0] warn_cond,
   input wire logic brake_fitted,
   input wire logic ready_in,
   input wire logic limit_in,
   input wire logic zero_in,
   input wire logic shared_clear_input,
   input wire logic position_req_input,
   output logic alarm_output,
   output logic motor_stop,
   output logic brake_engage,
   output logic warning_output,
   output logic ready_output,
   output logic limit_reached_output,
   output logic zero_phase_or_near_output,
   output logic position_clock_input,
   output logic fault_indicator_lamp,
   output logic irq
);

   // Counts must fit the lamp timer; refused while elaborating
   if (BLINK_ON_CYC < 1 || BLINK_ON_CYC >= (1 << SDAH_TMR_W) ||
       BLINK_GAP_CYC < 1 || BLINK_GAP_CYC >= (1 << SDAH_TMR_W))
   begin : g_bad_blink
      $error("sdah_top: blink counts out of range");
   end

   localparam logic [SDAH_TMR_W-1:0] ON_LAST = SDAH_TMR_W'(BLINK_ON_CYC - 1);
   localparam logic [SDAH_TMR_W-1:0] GAP_LAST = SDAH_TMR_W'(BLINK_GAP_CYC - 1);

   typedef struct packed {
      logic code_en;
      logic pos_mode;
      logic [1:0] clr_sync;
      logic [1:0] preq_sync;
      logic clr_prev;
      logic active;
      logic [3:0] cause;
      logic abs_arm;
      logic [SDAH_HIST_DEPTH-1:0][7:0] hist;
      logic [3:0] hist_cnt;
      logic [3:0] hist_sel;
      sdah_blink_e bst;
      logic [SDAH_TMR_W-1:0] btmr;
      logic [2:0] bidx;
      logic lamp;
      logic [SDAH_IRQ_W-1:0] irq_st;
      logic [SDAH_IRQ_W-1:0] irq_en;
      logic warn;
      logic [2:0] shout;
      logic pclk;
      logic ack;
      logic [31:0] rdata;
   } sdah_state_s;

   sdah_state_s s_reg;
   sdah_state_s s_next;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded helpers
   logic prio;
   logic clr_fall;
   logic wr_go;
   logic rd_start;
   logic cmd_wr;
   sdah_cause_s info;

   // Priority of position output; only the second sync stage is looked at
   assign prio = s_reg.pos_mode & s_reg.preq_sync[1];
   assign clr_fall = s_reg.clr_prev & ~s_reg.clr_sync[1];
   // Write lands on the edge where waitrequest is low
   assign wr_go = avs_write & s_reg.ack;
   assign rd_start = avs_read & ~s_reg.ack;
   assign cmd_wr = wr_go & (avs_address == SDAH_OFS_CMD) & avs_byteenable[0];
   assign info = sdah_cause_info(s_reg.cause);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic reset_req;
      logic [3:0] first;
      logic [SDAH_IRQ_W-1:0] ev;
      sdah_cause_s new_info;
      reset_req = 1'b0;
      first = 4'h0;
      ev = '0;
      new_info = sdah_cause_info(4'h0);
      s_next = s_reg;
      s_next.ack = (avs_read | avs_write) & ~s_reg.ack;
      s_next.clr_sync = {s_reg.clr_sync[0], shared_clear_input};
      s_next.preq_sync = {s_reg.preq_sync[0], position_req_input};
      s_next.clr_prev = s_reg.clr_sync[1];

      // Register writes
      if (wr_go && avs_byteenable[0])
      begin
         case (avs_address)
            SDAH_OFS_CTRL:
            begin
               s_next.code_en = avs_writedata[SDAH_CTRL_CODE_EN];
               s_next.pos_mode = avs_writedata[SDAH_CTRL_POS_MODE];
            end
            SDAH_OFS_HIST_SEL: s_next.hist_sel = avs_writedata[3:0];
            SDAH_OFS_IRQ_EN: s_next.irq_en = avs_writedata[SDAH_IRQ_W-1:0];
            default: ;
         endcase
      end

      // Reset sources; the clear pin is lost while it clocks position
      reset_req = (clr_fall & ~prio) | (cmd_wr & avs_writedata[SDAH_CMD_RESET]);
      if (cmd_wr && avs_writedata[SDAH_CMD_ABS_ARM])
         s_next.abs_arm = 1'b1;

      // History clear first so that a same-cycle alarm is still kept
      if (cmd_wr && avs_writedata[SDAH_CMD_HIST_CLR])
      begin
         s_next.hist = '0;
         s_next.hist_cnt = 4'h0;
      end

      // Alarm latch: first cause stays until a valid reset
      if (s_reg.active)
      begin
         if (reset_req && info.resettable && (s_reg.cause != SDAH_C_ABS_LOSS || s_reg.abs_arm))
         begin
            s_next.active = 1'b0;
            s_next.abs_arm = 1'b0;
            ev[SDAH_IRQ_CLEARED] = 1'b1;
         end
      end
      else if (|fault_event)
      begin
         for (int i = SDAH_NCAUSE - 1; i >= 0; i--)
            if (fault_event[i])
               first = 4'(i);
         s_next.active = 1'b1;
         s_next.cause = first;
         new_info = sdah_cause_info(first);
         s_next.hist = {s_next.hist[SDAH_HIST_DEPTH-2:0], new_info.code};
         if (s_next.hist_cnt < 4'(SDAH_HIST_DEPTH))
            s_next.hist_cnt = s_next.hist_cnt + 4'h1;
         ev[SDAH_IRQ_RAISED] = 1'b1;
      end

      // Warnings pass straight on from the condition inputs
      s_next.warn = |warn_cond;
      ev[SDAH_IRQ_WARN] = s_next.warn & ~s_reg.warn;

      // Shared outputs: code bits only when enabled and not overridden
      if (s_reg.active && s_reg.code_en && !prio)
         s_next.shout = info.al;
      else
         s_next.shout = {zero_in, limit_in, ready_in};
      s_next.pclk = prio & s_reg.clr_sync[1];

      // Lamp sequencer: groups of blinks, then a long gap
      case (s_reg.bst)
         BL_IDLE:
         begin
            s_next.btmr = '0;
            s_next.bidx = 3'h0;
            if (s_reg.active)
               s_next.bst = BL_ON;
         end
         BL_ON:
         begin
            s_next.btmr = s_reg.btmr + 1'b1;
            if (s_reg.btmr == ON_LAST)
            begin
               s_next.btmr = '0;
               s_next.bst = BL_OFF;
            end
         end
         BL_OFF:
         begin
            s_next.btmr = s_reg.btmr + 1'b1;
            if (s_reg.btmr == ON_LAST)
            begin
               s_next.btmr = '0;
               if (s_reg.bidx + 3'h1 >= info.blinks)
               begin
                  s_next.bidx = 3'h0;
                  s_next.bst = BL_GAP;
               end
               else
               begin
                  s_next.bidx = s_reg.bidx + 3'h1;
                  s_next.bst = BL_ON;
               end
            end
         end
         BL_GAP:
         begin
            s_next.btmr = s_reg.btmr + 1'b1;
            if (s_reg.btmr == GAP_LAST)
            begin
               s_next.btmr = '0;
               s_next.bst = BL_ON;
            end
         end
         default: s_next.bst = BL_IDLE;
      endcase
      // Gate on the next value so the lamp is dark the cycle the alarm clears
      if (!s_next.active)
         s_next.bst = BL_IDLE;
      s_next.lamp = (s_next.bst == BL_ON);

      // Sticky events; a new event beats a same-cycle clear
      s_next.irq_st = s_reg.irq_st | ev;
      if (wr_go && avs_byteenable[0] && avs_address == SDAH_OFS_IRQ_CLR)
         s_next.irq_st = (s_reg.irq_st & ~avs_writedata[SDAH_IRQ_W-1:0]) | ev;

      // Read data captured in the first cycle, shown in the second
      if (rd_start)
      begin
         case (avs_address)
            SDAH_OFS_CTRL: s_next.rdata = {30'h0, s_reg.pos_mode, s_reg.code_en};
            SDAH_OFS_STATUS: s_next.rdata = {16'h0, s_reg.active ? info.code : 8'h00,
                                             s_reg.active, 3'h0, s_reg.cause};
            SDAH_OFS_HIST_CNT: s_next.rdata = {28'h0, s_reg.hist_cnt};
            SDAH_OFS_HIST_SEL: s_next.rdata = {28'h0, s_reg.hist_sel};
            SDAH_OFS_HIST_DATA:
               s_next.rdata = (s_reg.hist_sel < s_reg.hist_cnt) ?
                  {24'h0, s_reg.hist[s_reg.hist_sel]} : 32'h0;
            SDAH_OFS_IRQ_STAT: s_next.rdata = {29'h0, s_reg.irq_st};
            SDAH_OFS_IRQ_EN: s_next.rdata = {29'h0, s_reg.irq_en};
            SDAH_OFS_WARN: s_next.rdata = {31'h0, s_reg.warn};
            default: s_next.rdata = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; power-up reset is the only clear for latched alarms that are not resettable
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.code_en <= SDAH_CODE_EN_RST;
         s_reg.pos_mode <= SDAH_POS_MODE_RST;
         s_reg.irq_en <= SDAH_IRQ_EN_RST;
         s_reg.bst <= BL_IDLE;
      end
      else
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.ack;
   assign avs_readdata = s_reg.rdata;
   assign alarm_output = ~s_reg.active;
   assign motor_stop = s_reg.active;
   assign brake_engage = s_reg.active & CUT_CURRENT_MASK[s_reg.cause] & brake_fitted;
   assign warning_output = s_reg.warn;
   assign ready_output = s_reg.shout[0];
   assign limit_reached_output = s_reg.shout[1];
   assign zero_phase_or_near_output = s_reg.shout[2];
   assign position_clock_input = s_reg.pclk;
   assign fault_indicator_lamp = s_reg.lamp;
   assign irq = |(s_reg.irq_st & s_reg.irq_en);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_alarm_stops;
      @(posedge clk) disable iff (rst)
      (!s_reg.active && |fault_event) |=> (!alarm_output && motor_stop);
   endproperty
   a_alarm_stops: assert property (p_alarm_stops) else $error("alarm did not stop motor");

   property p_code_route;
      @(posedge clk) disable iff (rst)
      (s_reg.active && s_reg.code_en && !prio) |=>
         ({zero_phase_or_near_output, limit_reached_output, ready_output} == $past(info.al));
   endproperty
   a_code_route: assert property (p_code_route) else $error("alarm code not routed");

   property p_prio_plain;
      @(posedge clk) disable iff (rst)
      prio |=> (ready_output == $past(ready_in) && zero_phase_or_near_output == $past(zero_in));
   endproperty
   a_prio_plain: assert property (p_prio_plain) else $error("code shown under position priority");

   property p_prio_no_reset;
      @(posedge clk) disable iff (rst)
      (prio && clr_fall && s_reg.active && !cmd_wr) |=> s_reg.active;
   endproperty
   a_prio_no_reset: assert property (p_prio_no_reset) else $error("clear pin reset under priority");

   property p_ov_three;
      @(posedge clk) disable iff (rst)
      (s_reg.active && s_reg.cause == SDAH_C_OVERVOLT && s_reg.bst == BL_OFF && s_reg.btmr == ON_LAST)
         |=> ((s_reg.bst == BL_GAP) == ($past(s_reg.bidx) == 3'h2));
   endproperty
   a_ov_three: assert property (p_ov_three) else $error("overvoltage group not three blinks");

   property p_pin_reset;
      @(posedge clk) disable iff (rst)
      (s_reg.active && clr_fall && !prio && info.resettable && s_reg.cause != SDAH_C_ABS_LOSS)
         |=> !s_reg.active;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("off edge did not clear alarm");

   property p_no_reset;
      @(posedge clk) disable iff (rst)
      (s_reg.active && !info.resettable) |=> (s_reg.active && $stable(s_reg.cause));
   endproperty
   a_no_reset: assert property (p_no_reset) else $error("power-cycle alarm was cleared");

   property p_abs_arm;
      @(posedge clk) disable iff (rst)
      (s_reg.active && s_reg.cause == SDAH_C_ABS_LOSS && !s_reg.abs_arm) |=> s_reg.active;
   endproperty
   a_abs_arm: assert property (p_abs_arm) else $error("position loss cleared without arming");

   property p_brake;
      @(posedge clk) disable iff (rst)
      (s_reg.active && brake_fitted && CUT_CURRENT_MASK[s_reg.cause]) |-> brake_engage;
   endproperty
   a_brake: assert property (p_brake) else $error("brake not engaged");

   property p_warn;
      @(posedge clk) disable iff (rst)
      (|warn_cond) |=> warning_output;
   endproperty
   a_warn: assert property (p_warn) else $error("warning not shown");

   property p_idle_on;
      @(posedge clk) disable iff (rst)
      !s_reg.active |-> (alarm_output && !motor_stop && !fault_indicator_lamp);
   endproperty
   a_idle_on: assert property (p_idle_on) else $error("alarm output low with no alarm");

endmodule // sdah_top

// ==== shared/sdah_pkg.sv ====
// Constants, cause table and register map of the servo alarm handler.
// Assumes a single 25 MHz clock; all time figures are converted here.
package sdah_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and lamp timing
   localparam int SDAH_CLK_HZ = 25_000_000;
   localparam int SDAH_BLINK_ON_MS = 200;
   localparam int SDAH_BLINK_GAP_MS = 1000;
   localparam int SDAH_BLINK_ON_CYC = SDAH_BLINK_ON_MS * (SDAH_CLK_HZ / 1000);
   localparam int SDAH_BLINK_GAP_CYC = SDAH_BLINK_GAP_MS * (SDAH_CLK_HZ / 1000);
   localparam int SDAH_TMR_W = 27;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [5:0] SDAH_OFS_CTRL = 6'h00;
   localparam logic [5:0] SDAH_OFS_STATUS = 6'h04;
   localparam logic [5:0] SDAH_OFS_CMD = 6'h08;
   localparam logic [5:0] SDAH_OFS_HIST_CNT = 6'h0c;
   localparam logic [5:0] SDAH_OFS_HIST_SEL = 6'h10;
   localparam logic [5:0] SDAH_OFS_HIST_DATA = 6'h14;
   localparam logic [5:0] SDAH_OFS_IRQ_STAT = 6'h18;
   localparam logic [5:0] SDAH_OFS_IRQ_CLR = 6'h1c;
   localparam logic [5:0] SDAH_OFS_IRQ_EN = 6'h20;
   localparam logic [5:0] SDAH_OFS_WARN = 6'h24;

   // Field positions
   localparam int SDAH_CTRL_CODE_EN = 0;
   localparam int SDAH_CTRL_POS_MODE = 1;
   localparam int SDAH_CMD_RESET = 0;
   localparam int SDAH_CMD_HIST_CLR = 1;
   localparam int SDAH_CMD_ABS_ARM = 2;
   localparam int SDAH_IRQ_RAISED = 0;
   localparam int SDAH_IRQ_WARN = 1;
   localparam int SDAH_IRQ_CLEARED = 2;
   localparam int SDAH_IRQ_W = 3;

   // Values after reset
   localparam logic SDAH_CODE_EN_RST = 1'b0;
   localparam logic SDAH_POS_MODE_RST = 1'b0;
   localparam logic [SDAH_IRQ_W-1:0] SDAH_IRQ_EN_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Alarm causes; index is the fault_event bit, lowest index wins
   localparam int SDAH_NCAUSE = 12;
   localparam int SDAH_HIST_DEPTH = 10;
   localparam logic [3:0] SDAH_C_OVERVOLT = 4'h6;
   localparam logic [3:0] SDAH_C_ABS_LOSS = 4'hb;

   typedef struct packed {
      logic [7:0] code;
      logic [2:0] blinks;
      logic [2:0] al;
      logic resettable;
   } sdah_cause_s;

   // Code, blinks per group, code bits {2,1,0}, reset by input or tool
   function automatic sdah_cause_s sdah_cause_info(input logic [3:0] c);
      case (c)
         4'h0: sdah_cause_info = '{8'h21, 3'h2, 3'h2, 1'b1};
         4'h1: sdah_cause_info = '{8'h26, 3'h2, 3'h2, 1'b0};
         4'h2: sdah_cause_info = '{8'h30, 3'h2, 3'h2, 1'b1};
         4'h3: sdah_cause_info = '{8'h31, 3'h2, 3'h2, 1'b1};
         4'h4: sdah_cause_info = '{8'h34, 3'h2, 3'h2, 1'b1};
         4'h5: sdah_cause_info = '{8'h51, 3'h3, 3'h3, 1'b0};
         4'h6: sdah_cause_info = '{8'h22, 3'h3, 3'h3, 1'b0};
         4'h7: sdah_cause_info = '{8'h23, 3'h3, 3'h3, 1'b1};
         4'h8: sdah_cause_info = '{8'h25, 3'h3, 3'h3, 1'b1};
         4'h9: sdah_cause_info = '{8'h10, 3'h4, 3'h4, 1'b1};
         4'ha: sdah_cause_info = '{8'h20, 3'h5, 3'h5, 1'b0};
         4'hb: sdah_cause_info = '{8'h19, 3'h7, 3'h7, 1'b1};
         default: sdah_cause_info = '{8'h00, 3'h1, 3'h0, 1'b1};
      endcase
   endfunction

   typedef enum logic [1:0] {BL_IDLE, BL_ON, BL_OFF, BL_GAP} sdah_blink_e;

endpackage

// ==== dv/sdah_host_model.sv ====
// Host controller model driving the shared clear pin of the alarm handler.
// Assumes the bench asks for a pulse with a one-cycle request, while the pin is idle.
`timescale 1ns/1ns
module sdah_host_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pulse_req,
   input wire logic [3:0] hold_cyc,
   output logic shared_clear_input
);
   logic [3:0] hold_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Pin goes on, stays on for hold_cyc plus one cycles, then off; a short hold is a prompt host
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         shared_clear_input <= 1'b0;
         hold_cnt <= 4'h0;
      end
      else if (pulse_req && !shared_clear_input)
      begin
         shared_clear_input <= 1'b1;
         hold_cnt <= hold_cyc;
      end
      else if (hold_cnt != 4'h0)
         hold_cnt <= hold_cnt - 4'h1;
      else
         shared_clear_input <= 1'b0;
   end
endmodule // sdah_host_model

// ==== dv/testbench.sv ====
// Self-checking bench of the alarm handler: Avalon master, host pin model, scenarios.
// Assumes short lamp timings (on 4, gap 10 cycles) and a 25 MHz clock.
`timescale 1ns/1ns
module testbench;
   import sdah_pkg::*;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, brake_fitted, ready_in, limit_in, zero_in;
   logic position_req_input, shared_clear_input, alarm_output, motor_stop, brake_engage, warning_output;
   logic ready_output, limit_reached_output, zero_phase_or_near_output, position_clock_input;
   logic fault_indicator_lamp, irq, pulse_req;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [SDAH_NCAUSE-1:0] fault_event, warn_cond;
   int fails, compares, cycles, n;
   logic p;

   ////////////////////////////////////////////////////////////////////////////
   // Clock, timeout and the two ends
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Generous ceiling; a hung bus wait also ends here
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         fails++;
         end_of_test();
      end
   end
   sdah_top #(.BLINK_ON_CYC(4), .BLINK_GAP_CYC(10)) u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_event(fault_event),
      .warn_cond(warn_cond), .brake_fitted(brake_fitted), .ready_in(ready_in), .limit_in(limit_in),
      .zero_in(zero_in), .shared_clear_input(shared_clear_input), .position_req_input(position_req_input),
      .alarm_output(alarm_output), .motor_stop(motor_stop), .brake_engage(brake_engage),
      .warning_output(warning_output), .ready_output(ready_output), .limit_reached_output(limit_reached_output),
      .zero_phase_or_near_output(zero_phase_or_near_output), .position_clock_input(position_clock_input),
      .fault_indicator_lamp(fault_indicator_lamp), .irq(irq));
   sdah_host_model u_host (.clk(clk), .rst(rst), .pulse_req(pulse_req), .hold_cyc(4'h6),
      .shared_clear_input(shared_clear_input));

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest is sampled low at a rising edge; data taken there
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   task automatic raise(input int c);
      @(posedge clk);
      fault_event <= 12'h1 << c;
      @(posedge clk);
      fault_event <= '0;
      #1;
   endtask
   task automatic count_blinks(input int cyc, output int cnt);
      logic prev;
      begin
         cnt = 0;
         prev = fault_indicator_lamp;
         repeat (cyc)
         begin
            @(posedge clk);
            #1;
            if (fault_indicator_lamp === 1'b1 && prev !== 1'b1)
               cnt++;
            prev = fault_indicator_lamp;
         end
      end
   endtask
   // Alarm must hold while the pin is on; reports whether the position clock moved
   task automatic pin_pulse(output logic pck);
      pck = 1'b0;
      @(posedge clk);
      pulse_req <= 1'b1;
      @(posedge clk);
      pulse_req <= 1'b0;
      repeat (18)
      begin
         @(posedge clk);
         #1;
         if (position_clock_input === 1'b1)
            pck = 1'b1;
         if (shared_clear_input === 1'b1)
            check(alarm_output, 1'b0);
      end
   endtask
   task automatic power_cycle;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      check(alarm_output, 1'b1);
      check(motor_stop, 1'b0);
      rdchk(SDAH_OFS_CTRL, 32'h0);
      rdchk(SDAH_OFS_IRQ_EN, 32'h0);
      rdchk(6'h3c, 32'h0);
      rdchk(SDAH_OFS_HIST_CNT, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_overvolt;
      brake_fitted <= 1'b1;
      raise(6);
      check(alarm_output, 1'b0);
      check(motor_stop, 1'b1);
      check(brake_engage, 1'b1);
      count_blinks(30, n);
      check(n, 3);
      rdchk(SDAH_OFS_STATUS, 32'h2286);
      pin_pulse(p);
      wr(SDAH_OFS_CMD, 32'h1);
      check(alarm_output, 1'b0);
      power_cycle();
      check(alarm_output, 1'b1);
      $display("test overvoltage done");
   endtask
   task automatic t_code_pin;
      wr(SDAH_OFS_CTRL, 32'h1);
      wr(SDAH_OFS_IRQ_EN, 32'h1);
      ready_in <= 1'b1;
      limit_in <= 1'b1;
      raise(9);
      count_blinks(40, n);
      check(n, 4);
      check({zero_phase_or_near_output, limit_reached_output, ready_output}, 3'h4);
      check(irq, 1'b1);
      wr(SDAH_OFS_CTRL, 32'h3);
      position_req_input <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check({zero_phase_or_near_output, limit_reached_output, ready_output}, 3'h3);
      pin_pulse(p);
      check(p, 1'b1);
      check(alarm_output, 1'b0);
      position_req_input <= 1'b0;
      repeat (6) @(posedge clk);
      pin_pulse(p);
      check(alarm_output, 1'b1);
      check(motor_stop, 1'b0);
      rdchk(SDAH_OFS_IRQ_STAT, 32'h5);
      wr(SDAH_OFS_IRQ_CLR, 32'h7);
      check(irq, 1'b0);
      rdchk(SDAH_OFS_IRQ_STAT, 32'h0);
      wr(SDAH_OFS_CTRL, 32'h0);
      $display("test code and pin done");
   endtask
   task automatic t_abs_loss;
      brake_fitted <= 1'b0;
      raise(11);
      check(brake_engage, 1'b0);
      wr(SDAH_OFS_CMD, 32'h1);
      check(alarm_output, 1'b0);
      wr(SDAH_OFS_CMD, 32'h4);
      wr(SDAH_OFS_CMD, 32'h1);
      @(posedge clk);
      #1;
      check(alarm_output, 1'b1);
      $display("test position loss done");
   endtask
   task automatic t_hist;
      wr(SDAH_OFS_CMD, 32'h2);
      rdchk(SDAH_OFS_HIST_CNT, 32'h0);
      for (int i = 0; i < 11; i++)
      begin
         raise((i % 2 == 1) ? 9 : 0);
         wr(SDAH_OFS_CMD, 32'h1);
      end
      rdchk(SDAH_OFS_HIST_CNT, 32'ha);
      wr(SDAH_OFS_HIST_SEL, 32'h0);
      rdchk(SDAH_OFS_HIST_DATA, 32'h21);
      wr(SDAH_OFS_HIST_SEL, 32'h1);
      rdchk(SDAH_OFS_HIST_DATA, 32'h10);
      wr(SDAH_OFS_HIST_SEL, 32'ha);
      rdchk(SDAH_OFS_HIST_DATA, 32'h0);
      wr(SDAH_OFS_CMD, 32'h2);
      rdchk(SDAH_OFS_HIST_CNT, 32'h0);
      $display("test history done");
   endtask
   task automatic t_warn;
      @(posedge clk);
      warn_cond <= 12'h040;
      repeat (2) @(posedge clk);
      #1;
      check(warning_output, 1'b1);
      check(alarm_output, 1'b1);
      rdchk(SDAH_OFS_WARN, 32'h1);
      rdchk(SDAH_OFS_IRQ_STAT, 32'h7);
      warn_cond <= '0;
      $display("test warning done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and main sequence
   task automatic end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      avs_address = 6'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      fault_event = '0;
      warn_cond = '0;
      brake_fitted = 1'b0;
      ready_in = 1'b0;
      limit_in = 1'b0;
      zero_in = 1'b0;
      position_req_input = 1'b0;
      pulse_req = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_overvolt();
      t_code_pin();
      t_abs_loss();
      t_hist();
      t_warn();
      end_of_test();
   end
endmodule // testbench
